//--- verilog/mmd_memory_map_decoder.sv
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/1ps
`include "mmd_defs.svh"

// Notes on behaviour
// - After reset registers decode at 0000-007F and RAM from 0080.
// - Register page field gives top hex digit; block spans x000-x07F.
// - Same page as registers: RAM at x080-x37F, or x080-x47F large.
// - Different pages: RAM at x000-x2FF (x3FF large), registers x000-x07F.
// - RAM/register relocation written once in normal modes, freely in special.
// - System configuration written once in normal modes, freely in special.
// - EEPROM relocation written once in normal modes, freely in special.
// - Program ROM decodes only while the ROM enable bit is one.
// - ROM at A000-FFFF; cleared address bit in expanded mode gives 2000-7FFF.
// - Large variant: ROM 8000-FFFF, or 0000-7FFF with address bit cleared.
// - Single-chip reset leaves ROM enable and ROM address bits set.
// - Special test reset forces ROM enable to zero until software sets it.
// - EEPROM at 0D80-0FFF after reset, only while its enable bit is one.
// - EEPROM page field places it at xD80-xFFF of any page.
// - Boot ROM BE00-BFFF only in special mode with boot enable set.
// - Both normal modes share the on-chip map except small-part ROM placement; external only when expanded.
// - Special flag latched as inverse of mode-B pin; software only clears.
// - Boot enable set by bootstrap reset or by special-mode writes; normal modes read zero.
module mmd_memory_map_decoder #(
  parameter bit LARGE_VARIANT = 1'b0
) (
  input  wire logic              core_clk,
  input  wire logic              arst_n,
  input  wire logic              mode_a_pin,
  input  wire logic              mode_b_pin,
  input  wire logic              cpuReq,
  input  wire logic [15:0]       cpuAddr,
  output logic                   selValid,
  output mmd_pkg::mmd_sel_t      selOut,
  output logic [15:0]            arrayOffset,
  output mmd_pkg::mmd_mode_t     modeStatus,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output logic [1:0]             s_axi_bresp,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  input  wire logic [7:0]        s_axi_araddr,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp
);
  import mmd_pkg::*;

  function automatic logic inRange(input logic [15:0] a,
                                   input logic [15:0] lo,
                                   input logic [15:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  function automatic logic isMapped(input logic [5:0] idx);
    return (idx == `MMD_IDX_PRIO) || (idx == `MMD_IDX_RELOC) ||
           (idx == `MMD_IDX_EEREL) || (idx == `MMD_IDX_CFG);
  endfunction

  // Pin synchronisers and startup sequence
  logic [1:0] modeASync_ff;
  logic [1:0] modeBSync_ff;
  logic [1:0] nxt_modeASync;
  logic [1:0] nxt_modeBSync;
  mmd_start_t state_ff;
  mmd_start_t nxt_state;
  logic       running;

  always_comb begin
    nxt_modeASync = {modeASync_ff[0], mode_a_pin};
    nxt_modeBSync = {modeBSync_ff[0], mode_b_pin};
    unique case (state_ff)
      SU_FILL1: nxt_state = SU_FILL2;
      SU_FILL2: nxt_state = SU_LATCH;
      SU_LATCH: nxt_state = SU_RUN;
      SU_RUN:   nxt_state = SU_RUN;
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      modeASync_ff <= 2'h0;
      modeBSync_ff <= 2'h0;
      state_ff     <= SU_FILL1;
    end else begin
      modeASync_ff <= nxt_modeASync;
      modeBSync_ff <= nxt_modeBSync;
      state_ff     <= nxt_state;
    end
  end

  assign running = (state_ff == SU_RUN);

  // AXI write channel
  logic       awHeld_ff;
  logic [5:0] awIdx_ff;
  logic       wHeld_ff;
  logic [7:0] wData_ff;
  logic       wLane_ff;
  logic       bvalid_ff;
  logic [1:0] bresp_ff;
  logic       nxt_awHeld;
  logic [5:0] nxt_awIdx;
  logic       nxt_wHeld;
  logic [7:0] nxt_wData;
  logic       nxt_wLane;
  logic       nxt_bvalid;
  logic [1:0] nxt_bresp;
  logic       wrFire;

  // Address and data may arrive in either order
  assign s_axi_awready = running && !awHeld_ff && !bvalid_ff;
  assign s_axi_wready  = running && !wHeld_ff && !bvalid_ff;
  assign wrFire        = awHeld_ff && wHeld_ff;

  always_comb begin
    nxt_awHeld = awHeld_ff;
    nxt_awIdx  = awIdx_ff;
    nxt_wHeld  = wHeld_ff;
    nxt_wData  = wData_ff;
    nxt_wLane  = wLane_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp  = bresp_ff;
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_awHeld = 1'b1;
      nxt_awIdx  = s_axi_awaddr[7:2];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_wHeld = 1'b1;
      nxt_wData = s_axi_wdata[7:0];
      nxt_wLane = s_axi_wstrb[0];
    end
    if (wrFire) begin
      nxt_awHeld = 1'b0;
      nxt_wHeld  = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp  = isMapped(awIdx_ff) ? `MMD_RESP_OKAY : `MMD_RESP_SLVERR;
    end else if (bvalid_ff && s_axi_bready) begin
      nxt_bvalid = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      awHeld_ff <= 1'b0;
      awIdx_ff  <= 6'h00;
      wHeld_ff  <= 1'b0;
      wData_ff  <= 8'h00;
      wLane_ff  <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff  <= `MMD_RESP_OKAY;
    end else begin
      awHeld_ff <= nxt_awHeld;
      awIdx_ff  <= nxt_awIdx;
      wHeld_ff  <= nxt_wHeld;
      wData_ff  <= nxt_wData;
      wLane_ff  <= nxt_wLane;
      bvalid_ff <= nxt_bvalid;
      bresp_ff  <= nxt_bresp;
    end
  end

  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp  = bresp_ff;

  // Mode and map registers
  logic       special_ff;
  logic       modeA_ff;
  logic       bootEn_ff;
  logic [7:0] cfg_ff;
  logic [7:0] reloc_ff;
  logic [3:0] eeRel_ff;
  logic       cfgDone_ff;
  logic       relocDone_ff;
  logic       eeDone_ff;
  logic       nxt_special;
  logic       nxt_modeA;
  logic       nxt_bootEn;
  logic [7:0] nxt_cfg;
  logic [7:0] nxt_reloc;
  logic [3:0] nxt_eeRel;
  logic       nxt_cfgDone;
  logic       nxt_relocDone;
  logic       nxt_eeDone;
  logic       regWrite;

  assign regWrite = wrFire && wLane_ff;

  always_comb begin
    nxt_special   = special_ff;
    nxt_modeA     = modeA_ff;
    nxt_bootEn    = bootEn_ff;
    nxt_cfg       = cfg_ff;
    nxt_reloc     = reloc_ff;
    nxt_eeRel     = eeRel_ff;
    nxt_cfgDone   = cfgDone_ff;
    nxt_relocDone = relocDone_ff;
    nxt_eeDone    = eeDone_ff;
    if (state_ff == SU_LATCH) begin
      nxt_special = ~modeBSync_ff[1];
      nxt_modeA   = modeASync_ff[1];
      nxt_bootEn  = ~modeBSync_ff[1] & ~modeASync_ff[1];
      nxt_cfg     = `MMD_CFG_RST;
      if (~modeBSync_ff[1] && modeASync_ff[1]) begin
        nxt_cfg[`MMD_BIT_ROMEN] = 1'b0;
      end
    end else if (regWrite) begin
      unique case (awIdx_ff)
        `MMD_IDX_PRIO: begin
          if (special_ff) begin
            nxt_modeA  = wData_ff[`MMD_BIT_MODEA];
            nxt_bootEn = wData_ff[`MMD_BIT_BOOTEN];
          end
          // Clear only; once normal, boot enable is dropped too
          nxt_special = special_ff & wData_ff[`MMD_BIT_SPECIAL];
          if (!(special_ff & wData_ff[`MMD_BIT_SPECIAL])) begin
            nxt_bootEn = 1'b0;
          end
        end
        `MMD_IDX_RELOC: begin
          if (special_ff || !relocDone_ff) begin
            nxt_reloc     = wData_ff;
            nxt_relocDone = 1'b1;
          end
        end
        `MMD_IDX_EEREL: begin
          if (special_ff || !eeDone_ff) begin
            nxt_eeRel  = wData_ff[3:0];
            nxt_eeDone = 1'b1;
          end
        end
        `MMD_IDX_CFG: begin
          if (special_ff || !cfgDone_ff) begin
            nxt_cfg     = wData_ff;
            nxt_cfgDone = 1'b1;
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      special_ff   <= 1'b0;
      modeA_ff     <= 1'b0;
      bootEn_ff    <= 1'b0;
      cfg_ff       <= `MMD_CFG_RST;
      reloc_ff     <= `MMD_RELOC_RST;
      eeRel_ff     <= `MMD_EEREL_RST;
      cfgDone_ff   <= 1'b0;
      relocDone_ff <= 1'b0;
      eeDone_ff    <= 1'b0;
    end else begin
      special_ff   <= nxt_special;
      modeA_ff     <= nxt_modeA;
      bootEn_ff    <= nxt_bootEn;
      cfg_ff       <= nxt_cfg;
      reloc_ff     <= nxt_reloc;
      eeRel_ff     <= nxt_eeRel;
      cfgDone_ff   <= nxt_cfgDone;
      relocDone_ff <= nxt_relocDone;
      eeDone_ff    <= nxt_eeDone;
    end
  end

  assign modeStatus = '{special: special_ff, modeA: modeA_ff,
                        bootEn: bootEn_ff & special_ff};

  // AXI read channel
  logic        rvalid_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  rresp_ff;
  logic        nxt_rvalid;
  logic [31:0] nxt_rdata;
  logic [1:0]  nxt_rresp;
  logic [7:0]  rdByte;
  logic [5:0]  rdIdx;

  assign s_axi_arready = running && !rvalid_ff;
  assign rdIdx         = s_axi_araddr[7:2];

  always_comb begin
    rdByte     = 8'h00;
    nxt_rvalid = rvalid_ff;
    nxt_rdata  = rdata_ff;
    nxt_rresp  = rresp_ff;
    unique case (rdIdx)
      `MMD_IDX_PRIO: begin
        rdByte[`MMD_BIT_BOOTEN]  = bootEn_ff & special_ff;
        rdByte[`MMD_BIT_SPECIAL] = special_ff;
        rdByte[`MMD_BIT_MODEA]   = modeA_ff;
      end
      `MMD_IDX_RELOC: rdByte = reloc_ff;
      `MMD_IDX_EEREL: rdByte = {4'h0, eeRel_ff};
      `MMD_IDX_CFG:   rdByte = cfg_ff;
      default:        rdByte = 8'h00;
    endcase
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_rvalid = 1'b1;
      nxt_rdata  = {24'h000000, rdByte};
      nxt_rresp  = isMapped(rdIdx) ? `MMD_RESP_OKAY : `MMD_RESP_SLVERR;
    end else if (rvalid_ff && s_axi_rready) begin
      nxt_rvalid = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= 32'h00000000;
      rresp_ff  <= `MMD_RESP_OKAY;
    end else begin
      rvalid_ff <= nxt_rvalid;
      rdata_ff  <= nxt_rdata;
      rresp_ff  <= nxt_rresp;
    end
  end

  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata  = rdata_ff;
  assign s_axi_rresp  = rresp_ff;

  // Address decode, registered one cycle
  logic [3:0]  regPage;
  logic [3:0]  ramPage;
  logic [11:0] ramFirst;
  logic [11:0] ramLast;
  logic [15:0] romFirst;
  logic [15:0] romLast;
  logic        regHit;
  logic        ramHit;
  logic        bootHit;
  logic        eeHit;
  logic        romHit;
  mmd_sel_t    sel_ff;
  mmd_sel_t    nxt_sel;
  logic        selValid_ff;
  logic        nxt_selValid;
  logic [15:0] offset_ff;
  logic [15:0] nxt_offset;

  always_comb begin
    regPage  = reloc_ff[`MMD_REGPG_HI:`MMD_REGPG_LO];
    ramPage  = reloc_ff[`MMD_RAMPG_HI:`MMD_RAMPG_LO];
    ramFirst = `MMD_RAM_OWN_FIRST;
    ramLast  = LARGE_VARIANT ? `MMD_RAM_OWN_LAST_L : `MMD_RAM_OWN_LAST_S;
    if (ramPage == regPage) begin
      ramFirst = `MMD_RAM_SH_FIRST;
      ramLast  = LARGE_VARIANT ? `MMD_RAM_SH_LAST_L : `MMD_RAM_SH_LAST_S;
    end
    // Low placement only takes effect in expanded mode on the small part
    if (LARGE_VARIANT) begin
      romFirst = cfg_ff[`MMD_BIT_ROMADDR] ? `MMD_ROM_HI_L : `MMD_ROM_LO_L;
      romLast  = cfg_ff[`MMD_BIT_ROMADDR] ? `MMD_ROM_TOP : `MMD_ROM_LO_LAST;
    end else if (cfg_ff[`MMD_BIT_ROMADDR] || !modeA_ff) begin
      romFirst = `MMD_ROM_HI_S;
      romLast  = `MMD_ROM_TOP;
    end else begin
      romFirst = `MMD_ROM_LO_S;
      romLast  = `MMD_ROM_LO_LAST;
    end
    regHit  = (cpuAddr[15:12] == regPage) &&
              (cpuAddr[11:0] <= `MMD_REG_LAST);
    ramHit  = (cpuAddr[15:12] == ramPage) &&
              inRange({4'h0, cpuAddr[11:0]}, {4'h0, ramFirst}, {4'h0, ramLast});
    bootHit = special_ff && bootEn_ff &&
              inRange(cpuAddr, `MMD_BOOT_FIRST, `MMD_BOOT_LAST);
    eeHit   = cfg_ff[`MMD_BIT_EEEN] && (cpuAddr[15:12] == eeRel_ff) &&
              inRange({4'h0, cpuAddr[11:0]}, {4'h0, `MMD_EE_FIRST},
                      {4'h0, `MMD_EE_LAST});
    romHit  = cfg_ff[`MMD_BIT_ROMEN] && inRange(cpuAddr, romFirst, romLast);
    nxt_sel      = '0;
    nxt_offset   = cpuAddr;
    nxt_selValid = cpuReq;
    if (cpuReq) begin
      if (regHit) begin
        nxt_sel.regSel = 1'b1;
        nxt_offset     = cpuAddr - {regPage, 12'h000};
      end else if (ramHit) begin
        nxt_sel.ramSel = 1'b1;
        nxt_offset     = cpuAddr - {ramPage, ramFirst};
      end else if (bootHit) begin
        nxt_sel.bootSel = 1'b1;
        nxt_offset      = cpuAddr - `MMD_BOOT_FIRST;
      end else if (eeHit) begin
        nxt_sel.eeSel = 1'b1;
        nxt_offset    = cpuAddr - {eeRel_ff, `MMD_EE_FIRST};
      end else if (romHit) begin
        nxt_sel.romSel = 1'b1;
        nxt_offset     = cpuAddr - romFirst;
      end else begin
        nxt_sel.extSel = modeA_ff;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sel_ff      <= '0;
      selValid_ff <= 1'b0;
      offset_ff   <= 16'h0000;
    end else begin
      sel_ff      <= nxt_sel;
      selValid_ff <= nxt_selValid;
      offset_ff   <= nxt_offset;
    end
  end

  assign selOut      = sel_ff;
  assign selValid    = selValid_ff;
  assign arrayOffset = offset_ff;

endmodule

//--- verilog/mmd_defs.svh
`ifndef MMD_DEFS_SVH
`define MMD_DEFS_SVH

// Register indices; byte address is four times the index
`define MMD_IDX_PRIO        6'h3c
`define MMD_IDX_RELOC       6'h3d
`define MMD_IDX_EEREL       6'h3e
`define MMD_IDX_CFG         6'h3f

// Field positions
`define MMD_BIT_ROMADDR     0
`define MMD_BIT_EEEN        1
`define MMD_BIT_ROMEN       2
`define MMD_BIT_MODEA       5
`define MMD_BIT_SPECIAL     6
`define MMD_BIT_BOOTEN      7
`define MMD_REGPG_HI        3
`define MMD_REGPG_LO        0
`define MMD_RAMPG_HI        7
`define MMD_RAMPG_LO        4

// Reset values
`define MMD_CFG_RST         8'h07
`define MMD_RELOC_RST       8'h00
`define MMD_EEREL_RST       4'h0

// Page-relative limits
`define MMD_REG_LAST        12'h07f
`define MMD_RAM_SH_FIRST    12'h080
`define MMD_RAM_SH_LAST_S   12'h37f
`define MMD_RAM_SH_LAST_L   12'h47f
`define MMD_RAM_OWN_FIRST   12'h000
`define MMD_RAM_OWN_LAST_S  12'h2ff
`define MMD_RAM_OWN_LAST_L  12'h3ff
`define MMD_EE_FIRST        12'hd80
`define MMD_EE_LAST         12'hfff

// Absolute limits
`define MMD_BOOT_FIRST      16'hbe00
`define MMD_BOOT_LAST       16'hbfff
`define MMD_ROM_HI_S        16'ha000
`define MMD_ROM_LO_S        16'h2000
`define MMD_ROM_HI_L        16'h8000
`define MMD_ROM_LO_L        16'h0000
`define MMD_ROM_LO_LAST     16'h7fff
`define MMD_ROM_TOP         16'hffff

// AXI responses
`define MMD_RESP_OKAY       2'b00
`define MMD_RESP_SLVERR     2'b10

`endif

//--- verilog/mmd_pkg.sv
package mmd_pkg;

  typedef enum logic [1:0] {
    SU_FILL1,
    SU_FILL2,
    SU_LATCH,
    SU_RUN
  } mmd_start_t;

  typedef struct packed {
    logic regSel;
    logic ramSel;
    logic bootSel;
    logic eeSel;
    logic romSel;
    logic extSel;
  } mmd_sel_t;

  typedef struct packed {
    logic special;
    logic modeA;
    logic bootEn;
  } mmd_mode_t;

endpackage

//--- sim/mmd_map_props.sv
`timescale 1ns/1ps
module mmd_map_props #(
  parameter bit LARGE_VARIANT = 1'b0
) (
  input wire logic               core_clk,
  input wire logic               arst_n,
  input wire logic               cpuReq,
  input wire logic [15:0]        cpuAddr,
  input wire logic               selValid,
  input wire mmd_pkg::mmd_sel_t  selOut,
  input wire logic [15:0]        arrayOffset,
  input wire mmd_pkg::mmd_mode_t modeStatus
);
  import mmd_pkg::*;

  logic [2:0] age_ff;
  logic [2:0] nxt_age;

  // Saturating age lets the mode latch edge pass before the flag is watched
  always_comb begin
    nxt_age = (age_ff == 3'h7) ? age_ff : age_ff + 3'h1;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      age_ff <= 3'h0;
    end else begin
      age_ff <= nxt_age;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  a_sel_onehot: assert property ($onehot0(selOut)) else $error("two selects");
  a_idle_quiet: assert property (!cpuReq |=> selOut == 6'h00 && !selValid)
    else $error("select without request");
  a_reg_window: assert property (selOut.regSel |-> $past(cpuAddr[11:0]) <= 12'h07f
    && arrayOffset == {4'h0, $past(cpuAddr[11:0])}) else $error("register window");
  a_ram_window: assert property (selOut.ramSel |-> arrayOffset <= 16'h03ff
    && (LARGE_VARIANT || arrayOffset <= 16'h02ff)) else $error("ram window");
  a_ee_window: assert property (selOut.eeSel |-> $past(cpuAddr[11:0]) >= 12'hd80
    && arrayOffset == {4'h0, $past(cpuAddr[11:0]) - 12'hd80}) else $error("eeprom window");
  a_boot_gate: assert property (selOut.bootSel |-> $past(modeStatus.special)
    && $past(modeStatus.bootEn) && $past(cpuAddr[15:9]) == 7'h5f) else $error("boot rom");
  a_rom_place: assert property (selOut.romSel |-> LARGE_VARIANT
    || $past(cpuAddr) inside {[16'h2000:16'h7fff], [16'ha000:16'hffff]}) else $error("rom");
  a_ext_mode: assert property (selOut.extSel |-> $past(modeStatus.modeA))
    else $error("external in single chip");
  a_special_once: assert property (age_ff >= 3'h4 |-> !$rose(modeStatus.special))
    else $error("special set by software");
  a_boot_normal: assert property (!modeStatus.special |-> !modeStatus.bootEn)
    else $error("boot enable in normal mode");
endmodule

bind mmd_memory_map_decoder mmd_map_props #(.LARGE_VARIANT(LARGE_VARIANT)) u_mmd_map_props (
  .core_clk(core_clk), .arst_n(arst_n), .cpuReq(cpuReq), .cpuAddr(cpuAddr),
  .selValid(selValid), .selOut(selOut), .arrayOffset(arrayOffset), .modeStatus(modeStatus)
);

//--- sim/mmd_cpu_model.sv
`timescale 1ns/1ps
module mmd_cpu_model (
  input  wire logic        core_clk,
  input  wire logic        arst_n,
  input  wire logic        go,
  input  wire logic [15:0] goAddr,
  output logic             cpuReq,
  output logic [15:0]      cpuAddr
);
  logic        req_ff;
  logic        nxt_req;
  logic [15:0] addr_ff;
  logic [15:0] nxt_addr;

  // Idle bus toggles so a stale address never looks like a live one
  always_comb begin
    nxt_req = go;
    nxt_addr = go ? goAddr : ~addr_ff;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      req_ff <= 1'b0;
      addr_ff <= 16'h0000;
    end else begin
      req_ff <= nxt_req;
      addr_ff <= nxt_addr;
    end
  end

  assign cpuReq = req_ff;
  assign cpuAddr = addr_ff;
endmodule

//--- sim/mmd_memory_map_decoder_tb.sv
`timescale 1ns/1ps
`include "mmd_defs.svh"
`define CHK(g, e) begin checksDone++; if ((g) !== (e)) begin numErrors++; $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module mmd_memory_map_decoder_tb;
  import mmd_pkg::*;
  logic        core_clk, arst_n, mode_a_pin, mode_b_pin, go, checkOn, sReq, cpuReq, selValid;
  logic [15:0] goAddr, sAddr, cpuAddr, arrayOffset, arrayOffsetL;
  mmd_sel_t    selOut, selOutL;
  mmd_mode_t   modeStatus;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, cfg, reloc;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb, eep, wr;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic        spec, modeA, boot;
  int          numErrors = 0;
  int          checksDone = 0;
  integer      seed;

  mmd_memory_map_decoder #(.LARGE_VARIANT(1'b0)) u_mmd_memory_map_decoder (
    .core_clk(core_clk), .arst_n(arst_n), .mode_a_pin(mode_a_pin), .mode_b_pin(mode_b_pin),
    .cpuReq(cpuReq), .cpuAddr(cpuAddr), .selValid(selValid), .selOut(selOut),
    .arrayOffset(arrayOffset), .modeStatus(modeStatus),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp));

  // Larger part shares every input; its register bus follows the small one in lockstep
  mmd_memory_map_decoder #(.LARGE_VARIANT(1'b1)) u_mmd_memory_map_decoder_large (
    .core_clk(core_clk), .arst_n(arst_n), .mode_a_pin(mode_a_pin), .mode_b_pin(mode_b_pin),
    .cpuReq(cpuReq), .cpuAddr(cpuAddr), .selValid(), .selOut(selOutL),
    .arrayOffset(arrayOffsetL), .modeStatus(),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(),
    .s_axi_araddr(s_axi_araddr), .s_axi_rvalid(), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(), .s_axi_rresp());

  mmd_cpu_model u_mmd_cpu_model (.core_clk(core_clk), .arst_n(arst_n), .go(go),
    .goAddr(goAddr), .cpuReq(cpuReq), .cpuAddr(cpuAddr));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic tallyAndFinish();
    if (numErrors == 0 && checksDone > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  function automatic logic [21:0] exp_map(input logic [15:0] a, input logic lg);
    logic [3:0]  rp;
    logic [3:0]  mp;
    logic [11:0] lo;
    rp = reloc[3:0];
    mp = reloc[7:4];
    lo = a[11:0];
    if (a[15:12] == rp && lo <= 12'h07f) return {6'h20, 4'h0, lo};
    if (a[15:12] == mp && mp == rp && lo >= 12'h080 && lo <= (lg ? 12'h47f : 12'h37f))
      return {6'h10, 4'h0, lo - 12'h080};
    if (a[15:12] == mp && mp != rp && lo <= (lg ? 12'h3ff : 12'h2ff)) return {6'h10, 4'h0, lo};
    if (spec && boot && a >= 16'hbe00 && a <= 16'hbfff) return {6'h08, a - 16'hbe00};
    if (cfg[1] && a[15:12] == eep && lo >= 12'hd80) return {6'h04, 4'h0, lo - 12'hd80};
    if (lg) begin
      if (cfg[2] && a[15] == cfg[0]) return {6'h02, 1'b0, a[14:0]};
    end else if (cfg[2] && modeA && !cfg[0]) begin
      // Low placement only with the external bus; single chip keeps the top
      if (a >= 16'h2000 && a <= 16'h7fff) return {6'h02, a - 16'h2000};
    end else if (cfg[2] && a >= 16'ha000) begin
      return {6'h02, a - 16'ha000};
    end
    return {modeA ? 6'h01 : 6'h00, a};
  endfunction

  function automatic logic [1:0] model_wr(input logic [5:0] i, input logic [7:0] d, input logic en);
    if (i < `MMD_IDX_PRIO) return `MMD_RESP_SLVERR;
    if (!en) return `MMD_RESP_OKAY;
    if (i == `MMD_IDX_PRIO) begin
      if (spec) begin
        modeA = d[5];
        boot = d[7] && d[6];
        spec = d[6];
      end
      return `MMD_RESP_OKAY;
    end
    if (!spec && wr[i[1:0]]) return `MMD_RESP_OKAY;
    wr[i[1:0]] = 1'b1;
    if (i == `MMD_IDX_RELOC) reloc = d;
    else if (i == `MMD_IDX_EEREL) eep = d[3:0];
    else cfg = d;
    return `MMD_RESP_OKAY;
  endfunction

  task automatic axi_do(input logic wrt, input logic [5:0] i, input logic [7:0] d,
                        input logic [3:0] s, output logic [31:0] q, output logic [1:0] r);
    logic ta, tw, tr, done;
    s_axi_awaddr <= {i, 2'b00};
    s_axi_araddr <= {i, 2'b00};
    s_axi_wdata <= {24'h000000, d};
    s_axi_wstrb <= s;
    s_axi_awvalid <= wrt;
    s_axi_wvalid <= wrt;
    s_axi_bready <= wrt;
    s_axi_arvalid <= !wrt;
    s_axi_rready <= !wrt;
    done = 1'b0;
    while (!done) begin
      @(negedge core_clk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tr = s_axi_arvalid && s_axi_arready;
      done = wrt ? s_axi_bvalid : s_axi_rvalid;
      r = wrt ? s_axi_bresp : s_axi_rresp;
      q = s_axi_rdata;
      @(posedge core_clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      if (tr) s_axi_arvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    // Answer must be gone once its ready has been seen
    @(negedge core_clk);
    `CHK(wrt ? s_axi_bvalid : s_axi_rvalid, 1'b0)
    @(posedge core_clk);
  endtask

  task automatic check_read(input logic [5:0] i);
    logic [31:0] q;
    logic [1:0]  r;
    logic [8:0]  e;
    e = (i == `MMD_IDX_PRIO) ? {1'b0, boot, spec, modeA, 5'h00} : (i == `MMD_IDX_RELOC) ?
        {1'b0, reloc} : (i == `MMD_IDX_EEREL) ? {5'h00, eep} : (i == `MMD_IDX_CFG) ? {1'b0, cfg} : 9'h100;
    axi_do(1'b0, i, 8'h00, 4'h0, q, r);
    `CHK(q, {24'h000000, e[7:0]})
    `CHK(r, e[8] ? `MMD_RESP_SLVERR : `MMD_RESP_OKAY)
  endtask

  task automatic do_reset(input logic b, input logic a);
    arst_n <= 1'b0;
    mode_b_pin <= b;
    mode_a_pin <= a;
    repeat (5) @(posedge core_clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    mode_a_pin <= 1'($random(seed));
    mode_b_pin <= 1'($random(seed));
    spec = !b;
    modeA = a;
    boot = !b && !a;
    cfg = (!b && a) ? 8'h03 : 8'h07;
    reloc = 8'h00;
    eep = 4'h0;
    wr = 4'h0;
  endtask

  task automatic sweep();
    logic [15:0] lst[$];
    lst = {16'h0000, 16'h007f, 16'h0080, 16'h037f, 16'h0380, 16'h0d7f, 16'h0d80, 16'h0fff,
           16'h1fff, 16'h2000, 16'h7fff, 16'h8000, 16'h9fff, 16'ha000, 16'hbdff, 16'hbe00,
           16'hbfff, 16'hffff, {reloc[3:0], 12'h07f}, {reloc[3:0], 12'h080},
           {reloc[7:4], 12'h000}, {reloc[7:4], 12'h2ff}, {reloc[7:4], 12'h300},
           {reloc[7:4], 12'h37f}, {eep, 12'hd7f}, {eep, 12'hd80}};
    repeat (8) lst.push_back(16'($random(seed)));
    checkOn = 1'b1;
    foreach (lst[k]) begin
      go <= 1'b1;
      goAddr <= lst[k];
      @(posedge core_clk);
      if (($random(seed) & 3) == 0) begin
        go <= 1'b0;
        @(posedge core_clk);
      end
    end
    go <= 1'b0;
    repeat (3) @(posedge core_clk);
    checkOn = 1'b0;
  endtask

  always @(posedge core_clk) begin
    sReq <= cpuReq;
    sAddr <= cpuAddr;
  end

  always @(negedge core_clk) begin
    if (checkOn) begin
      `CHK(selValid, sReq)
      `CHK(modeStatus, {spec, modeA, boot})
      if (sReq) begin
        `CHK({selOut, arrayOffset}, exp_map(sAddr, 1'b0))
        `CHK({selOutL, arrayOffsetL}, exp_map(sAddr, 1'b1))
      end else begin
        `CHK(selOut, 6'h00)
        `CHK(selOutL, 6'h00)
      end
    end
  end

  initial begin
    repeat (30000) @(posedge core_clk);
    numErrors++;
    tallyAndFinish();
  end

  initial begin
    logic [5:0]  i;
    logic [7:0]  d;
    logic [3:0]  s;
    logic [31:0] q;
    logic [1:0]  r;
    logic [1:0]  e;
    seed = 32'haaa8;
    arst_n = 1'b0;
    mode_a_pin = 1'b0;
    mode_b_pin = 1'b1;
    go = 1'b0;
    goAddr = 16'h0000;
    checkOn = 1'b0;
    s_axi_awvalid = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_wvalid = 1'b0;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'h0;
    s_axi_bready = 1'b0;
    s_axi_arvalid = 1'b0;
    s_axi_araddr = 8'h00;
    s_axi_rready = 1'b0;
    for (int it = 0; it < 8; it++) begin
      do_reset(it[1], it[0]);
      `CHK(modeStatus, {spec, modeA, boot})
      for (int k = 0; k < 5; k++) begin
        check_read(6'h3b + 6'(k));
      end
      sweep();
      repeat (8) begin
        i = (($random(seed) & 7) == 0) ? 6'($random(seed) & 59) : 6'h3c + 6'($random(seed) & 3);
        d = 8'($random(seed));
        s = (($random(seed) & 7) == 0) ? 4'he : 4'hf;
        e = model_wr(i, d, s[0]);
        axi_do(1'b1, i, d, s, q, r);
        `CHK(r, e)
        check_read(i);
      end
      sweep();
    end
    tallyAndFinish();
  end
endmodule
